/* verilog/mpf_pkg.sv */
package mpf_pkg;

  // command codes seen on the command port
  localparam logic [7:0] MPF_CMD_END        = 8'h80;  // end program
  localparam logic [7:0] MPF_CMD_TICK_DELAY = 8'h8c;  // tick delay, also the millisecond form
  localparam logic [7:0] MPF_CMD_CLEAR_PEAK = 8'h93;  // clear peak error
  localparam logic [7:0] MPF_CMD_LOOP_START = 8'hd1;  // loop start
  localparam logic [7:0] MPF_CMD_LOOP_NEXT  = 8'hd2;  // loop next

  // register indices answered on the read path
  localparam logic [15:0] MPF_REG_DELAY = 16'h0005;  // shared delay counter
  localparam logic [15:0] MPF_REG_PEAK  = 16'h0006;  // peak position error

  // peak tracker ceiling, one signed word
  localparam logic [15:0] MPF_PEAK_MAX = 16'h7fff;

  // servo tick timing
  localparam int MPF_CLK_NS   = 10;                              // clock period in ns
  localparam int MPF_TICK_US  = 120;                             // servo cycle in us
  localparam int MPF_TICK_CYC = (MPF_TICK_US * 1000) / MPF_CLK_NS;  // cycles per tick

  // loop record layout: value, final, increment
  localparam int MPF_LREC_W       = 96;
  localparam int MPF_LREC_VAL_LSB = 64;
  localparam int MPF_LREC_FIN_LSB = 32;
  localparam int MPF_LREC_INC_LSB = 0;

  // sequencer states, one-hot
  typedef enum logic [1:0]
  {
    MPF_IDLE = 2'b01,
    MPF_EVAL = 2'b10
  } mpf_fsm_t;

  // state of the flow unit except the loop record store
  typedef struct packed
  {
    mpf_fsm_t    st;           // sequencer state
    logic        ready;        // command port may take a word
    logic [31:0] tick_cnt;     // servo tick divider
    logic        tick;         // servo tick pulse
    logic [15:0] peak;         // peak absolute error
    logic [31:0] dly;          // shared delay counter
    logic [1:0]  wait_on;      // per-thread hold
    logic        host_mode;    // motor in host mode
    logic        prog_stop;    // program stopped pulse
    logic        ack;          // acknowledge pulse
    logic        ack_thread;   // thread of acknowledged command
    logic        nxt_thread;   // thread of pending loop next
    logic [15:0] nxt_reg;      // loop register of pending loop next
    logic        loop_branch;  // loop repeats
    logic        loop_done;    // loop finished
    logic        reg_wr_en;    // loop register write strobe
    logic [15:0] reg_wr_addr;  // loop register index
    logic [31:0] reg_wr_data;  // loop register value
    logic        rd_valid;     // read answer strobe
    logic [31:0] rd_data;      // read answer data
    logic        pb_wr_en;     // program buffer append strobe
    logic [15:0] pb_wr_addr;   // program buffer append address
    logic [15:0] pb_wr_data;   // program buffer append word
  } mpf_core_t;

  // value after reset: host mode, port ready
  localparam mpf_core_t MPF_CORE_RST = '{st: MPF_IDLE, ready: 1'b1, host_mode: 1'b1, default: '0};

endpackage

/* verilog/mpf_loop_mem_if.sv */
`timescale 1ns/100ps
// carries loop records between sequencer and record store
interface mpf_loop_mem_if #(
  parameter int AW = 3,
  parameter int DW = 96
);
  logic          we;     // write strobe
  logic [AW-1:0] waddr;  // write slot
  logic [DW-1:0] wdata;  // write record
  logic [AW-1:0] raddr;  // read slot
  logic [DW-1:0] rdata;  // registered read record

  modport ctl
  (
    output we,
    output waddr,
    output wdata,
    output raddr,
    input  rdata
  );

  modport mem
  (
    input  we,
    input  waddr,
    input  wdata,
    input  raddr,
    output rdata
  );
endinterface

/* verilog/mpf_loop_mem.sv */
`timescale 1ns/100ps
// small record store, read data from a register
module mpf_loop_mem #(
  parameter int AW = 3,
  parameter int DW = 96
)
(
  input wire logic       clock,
  mpf_loop_mem_if.mem    port
);

  logic [DW-1:0] store [2**AW];  // one record per loop slot

  // read before write, registered; same-slot read returns old record
  always_ff @(posedge clock)
  begin
    if (port.we)
    begin
      store[port.waddr] <= port.wdata;
    end
    port.rdata <= store[port.raddr];
  end

endmodule

/* verilog/mpf_flow_unit.sv */
`timescale 1ns/100ps
module mpf_flow_unit
  import mpf_pkg::*;
#(
  parameter int TICK_CYCLES = MPF_TICK_CYC,  // servo tick period in clocks
  parameter int SLOT_W      = 3              // log2 of loop slots
)
(
  input  wire logic        clock,             // system clock
  input  wire logic        sys_rst,           // synchronous reset
  input  wire logic        cmd_valid,         // command word present
  input  wire logic        cmd_thread,        // issuing thread, 0 or 1
  input  wire logic [7:0]  cmd_code,          // command code
  input  wire logic [31:0] cmd_arg_a,         // count or initial value
  input  wire logic [31:0] cmd_arg_b,         // final value
  input  wire logic [31:0] cmd_arg_c,         // increment
  input  wire logic [15:0] cmd_reg,           // loop register index
  output logic             cmd_ready,         // command port free
  output logic             ack,               // acknowledge pulse
  output logic             ack_thread,        // thread being acknowledged
  output logic [1:0]       thread_wait,       // per-thread delay hold
  input  wire logic [31:0] pos_err,           // signed position error
  output logic [15:0]      peak_error,        // peak absolute error
  input  wire logic        prog_run,          // program started pulse
  output logic             host_mode,         // motor in host mode
  output logic             prog_stop,         // program ended pulse
  output logic             loop_branch,       // loop body repeats
  output logic             loop_done,         // loop finished
  output logic             reg_wr_en,         // loop register write
  output logic [15:0]      reg_wr_addr,       // loop register index
  output logic [31:0]      reg_wr_data,       // loop register value
  input  wire logic        rd_en,             // register read request
  input  wire logic [15:0] rd_addr,           // register index
  output logic             rd_valid,          // read answer strobe
  output logic [31:0]      rd_data,           // read answer
  input  wire logic        pb_load_done,      // program load finished
  input  wire logic [15:0] pb_load_end_addr,  // last loaded word address
  output logic             pb_wr_en,          // append strobe
  output logic [15:0]      pb_wr_addr,        // append address
  output logic [15:0]      pb_wr_data         // appended word
);

  mpf_core_t s_q;  // registered state
  mpf_core_t s_d;  // next state

  // loop record store link
  mpf_loop_mem_if #(.AW(SLOT_W), .DW(MPF_LREC_W)) lmem ();

  mpf_loop_mem #(
    .AW (SLOT_W),
    .DW (MPF_LREC_W)
  ) u_loop_mem (
    .clock (clock),
    .port  (lmem.mem)
  );

  // decoded command strobes, also watched by the checks below
  logic take;        // command word taken this cycle
  logic take_clear;  // clear peak taken
  logic take_delay;  // delay taken
  logic take_end;    // end program taken
  logic take_start;  // loop start taken
  logic take_next;   // loop next taken

  assign take       = cmd_valid && s_q.ready;
  assign take_clear = take && (cmd_code == MPF_CMD_CLEAR_PEAK);
  assign take_delay = take && (cmd_code == MPF_CMD_TICK_DELAY);
  assign take_end   = take && (cmd_code == MPF_CMD_END);
  assign take_start = take && (cmd_code == MPF_CMD_LOOP_START);
  assign take_next  = take && (cmd_code == MPF_CMD_LOOP_NEXT);

  // error magnitude, widened so the most negative error cannot wrap
  logic signed [32:0] err_ext;  // sign-extended error
  logic        [32:0] err_abs;  // absolute error
  logic        [15:0] err_sat;  // saturated to one word

  assign err_ext = {pos_err[31], pos_err};
  assign err_abs = err_ext[32] ? 33'(-err_ext) : 33'(err_ext);
  assign err_sat = (err_abs > {17'h0_0000, MPF_PEAK_MAX}) ? MPF_PEAK_MAX : err_abs[15:0];

  // delay magnitude; out-of-range most negative count is not handled
  logic [31:0] dly_mag;  // absolute tick count

  assign dly_mag = cmd_arg_a[31] ? 32'(-$signed(cmd_arg_a)) : cmd_arg_a;

  // loop next arithmetic on the record read back from the store
  logic signed [31:0] lp_val;   // loop register before step
  logic signed [31:0] lp_fin;   // final value
  logic signed [31:0] lp_inc;   // increment
  logic signed [31:0] lp_new;   // stepped value, wraps at 32 bits
  logic               lp_end;   // loop terminates

  assign lp_val = lmem.rdata[MPF_LREC_VAL_LSB +: 32];
  assign lp_fin = lmem.rdata[MPF_LREC_FIN_LSB +: 32];
  assign lp_inc = lmem.rdata[MPF_LREC_INC_LSB +: 32];
  assign lp_new = lp_val + lp_inc;
  // zero increment follows the upward test
  assign lp_end = lp_inc[31] ? (lp_new < lp_fin) : (lp_new > lp_fin);

  // next-state logic for the whole unit
  always_comb
  begin
    s_d = s_q;
    // pulses default low
    s_d.tick        = 1'b0;
    s_d.ack         = 1'b0;
    s_d.prog_stop   = 1'b0;
    s_d.loop_branch = 1'b0;
    s_d.loop_done   = 1'b0;
    s_d.reg_wr_en   = 1'b0;
    s_d.rd_valid    = 1'b0;
    s_d.pb_wr_en    = 1'b0;
    // record store idle unless a loop command drives it
    lmem.we    = 1'b0;
    lmem.waddr = cmd_reg[SLOT_W-1:0];
    lmem.wdata = {cmd_arg_a, cmd_arg_b, cmd_arg_c};
    lmem.raddr = cmd_reg[SLOT_W-1:0];

    // servo tick divider
    if (s_q.tick_cnt == 32'(TICK_CYCLES - 1))
    begin
      s_d.tick_cnt = '0;
      s_d.tick     = 1'b1;
    end
    else
    begin
      s_d.tick_cnt = s_q.tick_cnt + 32'h0000_0001;
    end

    // peak tracker; a tick meeting a clear restarts from that sample
    if (take_clear)
    begin
      s_d.peak = s_q.tick ? err_sat : 16'h0000;
    end
    else if (s_q.tick && (err_sat > s_q.peak))
    begin
      s_d.peak = err_sat;
    end

    // shared delay counter, load beats a same-cycle tick
    if (take_delay)
    begin
      s_d.dly = dly_mag;
    end
    else if (s_q.tick && (s_q.dly != 32'h0000_0000))
    begin
      s_d.dly = s_q.dly - 32'h0000_0001;
    end

    // holds drop once the counter is exhausted, for both threads
    if (s_d.dly == 32'h0000_0000)
    begin
      s_d.wait_on = 2'b00;
    end
    if (take_delay && !cmd_arg_a[31] && (cmd_arg_a != 32'h0000_0000))
    begin
      s_d.wait_on[cmd_thread] = 1'b1;
    end

    // program start leaves host mode
    if (prog_run)
    begin
      s_d.host_mode = 1'b0;
    end

    // command sequencer
    case (s_q.st)
      MPF_IDLE:
      begin
        // every recognised code except loop next answers at once
        if (take_clear || take_delay || take_end || take_start)
        begin
          s_d.ack        = 1'b1;
          s_d.ack_thread = cmd_thread;
        end
        // end is a no-op when already in host mode
        if (take_end && !s_q.host_mode)
        begin
          s_d.host_mode = 1'b1;
          s_d.prog_stop = 1'b1;
        end
        // loop start: record and initial register write
        if (take_start)
        begin
          lmem.we         = 1'b1;
          s_d.reg_wr_en   = 1'b1;
          s_d.reg_wr_addr = cmd_reg;
          s_d.reg_wr_data = cmd_arg_a;
        end
        // loop next: fetch the record, evaluate next cycle
        if (take_next)
        begin
          s_d.st         = MPF_EVAL;
          s_d.ready      = 1'b0;
          s_d.nxt_thread = cmd_thread;
          s_d.nxt_reg    = cmd_reg;
        end
      end
      MPF_EVAL:
      begin
        // write back stepped value, keep final and increment
        lmem.we         = 1'b1;
        lmem.waddr      = s_q.nxt_reg[SLOT_W-1:0];
        lmem.wdata      = {lp_new, lp_fin, lp_inc};
        s_d.reg_wr_en   = 1'b1;
        s_d.reg_wr_addr = s_q.nxt_reg;
        s_d.reg_wr_data = lp_new;
        s_d.loop_done   = lp_end;
        s_d.loop_branch = !lp_end;
        s_d.ack         = 1'b1;
        s_d.ack_thread  = s_q.nxt_thread;
        s_d.st          = MPF_IDLE;
        s_d.ready       = 1'b1;
      end
      default:
      begin
        // recover from a corrupted state code
        s_d.st    = MPF_IDLE;
        s_d.ready = 1'b1;
      end
    endcase

    // register read path, answers one cycle later
    if (rd_en)
    begin
      s_d.rd_valid = 1'b1;
      if (rd_addr == MPF_REG_DELAY)
      begin
        s_d.rd_data = s_q.dly;
      end
      else if (rd_addr == MPF_REG_PEAK)
      begin
        s_d.rd_data = {16'h0000, s_q.peak};
      end
      else
      begin
        s_d.rd_data = 32'h0000_0000;  // other registers live elsewhere
      end
    end

    // append an end word after a freshly loaded program
    if (pb_load_done)
    begin
      s_d.pb_wr_en   = 1'b1;
      s_d.pb_wr_addr = pb_load_end_addr + 16'h0001;
      s_d.pb_wr_data = {8'h00, MPF_CMD_END};
    end
  end

  // single state register
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s_q <= MPF_CORE_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign cmd_ready   = s_q.ready;
  assign ack         = s_q.ack;
  assign ack_thread  = s_q.ack_thread;
  assign thread_wait = s_q.wait_on;
  assign peak_error  = s_q.peak;
  assign host_mode   = s_q.host_mode;
  assign prog_stop   = s_q.prog_stop;
  assign loop_branch = s_q.loop_branch;
  assign loop_done   = s_q.loop_done;
  assign reg_wr_en   = s_q.reg_wr_en;
  assign reg_wr_addr = s_q.reg_wr_addr;
  assign reg_wr_data = s_q.reg_wr_data;
  assign rd_valid    = s_q.rd_valid;
  assign rd_data     = s_q.rd_data;
  assign pb_wr_en    = s_q.pb_wr_en;
  assign pb_wr_addr  = s_q.pb_wr_addr;
  assign pb_wr_data  = s_q.pb_wr_data;

  // checks on the unit's own behaviour
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence next_taken_s;
    take_next;
  endsequence

  sequence next_eval_s;
    s_q.st == MPF_EVAL;
  endsequence

  // peak never above one signed word
  peak_saturated_a: assert property (s_q.peak <= MPF_PEAK_MAX)
    else $error("peak error above saturation value");

  // clear without tick gives zero
  peak_cleared_a: assert property (take_clear && !s_q.tick |=> s_q.peak == 16'h0000)
    else $error("peak error not cleared");

  // tick without clear never lowers the peak and catches the sample
  peak_tracks_a: assert property (s_q.tick && !take_clear |=>
                                  s_q.peak >= $past(s_q.peak) && s_q.peak >= $past(err_sat))
    else $error("peak error failed to track");

  // delay load takes the magnitude
  delay_loaded_a: assert property (take_delay |=> s_q.dly == $past(dly_mag))
    else $error("delay counter not loaded");

  // counter drops by exactly one per tick
  delay_counts_a: assert property (s_q.tick && !take_delay && s_q.dly != 32'h0 |=>
                                   s_q.dly == $past(s_q.dly) - 32'h1)
    else $error("delay counter step wrong");

  // positive count holds the issuing thread
  delay_holds_a: assert property (take_delay && !cmd_arg_a[31] && cmd_arg_a != 32'h0 |=>
                                  s_q.wait_on[$past(cmd_thread)])
    else $error("positive delay did not hold thread");

  // negative count leaves an idle thread free
  delay_no_hold_a: assert property (take_delay && cmd_arg_a[31] && !s_q.wait_on[cmd_thread] |=>
                                    !s_q.wait_on[$past(cmd_thread)])
    else $error("negative delay held thread");

  // end in program mode stops; in host mode does nothing
  end_stops_a: assert property (take_end |=> s_q.host_mode && (s_q.prog_stop == !$past(s_q.host_mode)))
    else $error("end program handling wrong");

  // loop next answers two cycles on with exactly one outcome
  next_outcome_a: assert property (next_taken_s ##1 next_eval_s |=>
                                   s_q.ack && (s_q.loop_branch ^ s_q.loop_done) && s_q.reg_wr_en)
    else $error("loop next outcome missing");

  // other commands acknowledged on the next cycle
  cmd_acked_a: assert property (take_clear || take_delay || take_end || take_start |=>
                                s_q.ack && s_q.ack_thread == $past(cmd_thread))
    else $error("command not acknowledged");

  // load completion appends an end word after the last address
  end_appended_a: assert property (pb_load_done |=> s_q.pb_wr_en && s_q.pb_wr_data == {8'h00, MPF_CMD_END}
                                   && s_q.pb_wr_addr == $past(pb_load_end_addr) + 16'h1)
    else $error("end word not appended");

endmodule

/* dv/mpf_host_model.sv */
`timescale 1ns/100ps
// host end of the command port, one whole command at a time
module mpf_host_model
  import mpf_pkg::*;
(
  input  wire logic        clock,      // system clock
  input  wire logic        cmd_ready,  // device can take a command
  output logic             cmd_valid,  // command present
  output logic             cmd_thread, // issuing thread
  output logic [7:0]       cmd_code,   // command code
  output logic [31:0]      cmd_arg_a,  // count or initial value
  output logic [31:0]      cmd_arg_b,  // final value
  output logic [31:0]      cmd_arg_c,  // increment
  output logic [15:0]      cmd_reg     // loop register index
);
  // port idle from time zero
  initial
  begin
    cmd_valid  = 1'b0;
    cmd_thread = 1'b0;
    cmd_code   = 8'h00;
    cmd_arg_a  = 32'h0;
    cmd_arg_b  = 32'h0;
    cmd_arg_c  = 32'h0;
    cmd_reg    = 16'h0;
  end

  // drive after an edge, hold until an edge sees ready high
  task automatic send(input logic t, input logic [7:0] c, input logic [31:0] a, input logic [31:0] b,
                      input logic [31:0] i, input logic [15:0] r);
    @(posedge clock);
    #1;
    cmd_valid  = 1'b1;
    cmd_thread = t;
    cmd_code   = c;
    cmd_arg_a  = a;
    cmd_arg_b  = b;
    cmd_arg_c  = i;
    cmd_reg    = r;
    // ready drops for one cycle after loop next
    while (cmd_ready !== 1'b1)
    begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1;
    // released fields flip so a stale command never looks valid
    cmd_valid  = 1'b0;
    cmd_thread = ~t;
    cmd_code   = ~c;
    cmd_arg_a  = ~a;
    cmd_arg_b  = ~b;
    cmd_arg_c  = ~i;
    cmd_reg    = ~r;
  endtask

  // millisecond form: scaled here, the device never scales
  task automatic send_ms(input logic t, input int ms);
    int ticks;
    ticks = (ms * 83333) / 10000;
    send(t, MPF_CMD_TICK_DELAY, 32'(ticks), 32'h0, 32'h0, 16'h0);
  endtask
endmodule

/* dv/motion_program_flow_unit_test.sv */
`timescale 1ns/100ps
// self-checking bench: drivers note results, monitor compares
module motion_program_flow_unit_test;
  import mpf_pkg::*;
  localparam int TC = 10;  // short servo tick keeps the run brief
  logic clock = 1'b0;  // system clock
  logic sys_rst = 1'b1;  // synchronous reset
  logic cmd_valid, cmd_thread, cmd_ready, ack, ack_thread, host_mode, prog_stop, prog_run;
  logic loop_branch, loop_done, reg_wr_en, rd_en, rd_valid, pb_load_done, pb_wr_en;
  logic [7:0]  cmd_code;  // command code
  logic [31:0] cmd_arg_a, cmd_arg_b, cmd_arg_c, pos_err, reg_wr_data, rd_data, e;
  logic [15:0] cmd_reg, peak_error, reg_wr_addr, rd_addr, pb_load_end_addr, pb_wr_addr, pb_wr_data;
  logic [1:0]  thread_wait;  // per-thread hold
  logic [31:0] q_ack[$], q_wr[$], q_wa[$], q_loop[$], q_rd[$], q_pb[$], q_stop[$];  // expected results
  int          failures = 0;
  int          checked = 0;
  int          n;

  always #5 clock = ~clock;

  mpf_host_model i_host (.clock(clock), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd_thread(cmd_thread),
    .cmd_code(cmd_code), .cmd_arg_a(cmd_arg_a), .cmd_arg_b(cmd_arg_b), .cmd_arg_c(cmd_arg_c), .cmd_reg(cmd_reg));

  mpf_flow_unit #(.TICK_CYCLES(TC)) i_dut (.clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_thread(cmd_thread), .cmd_code(cmd_code), .cmd_arg_a(cmd_arg_a), .cmd_arg_b(cmd_arg_b),
    .cmd_arg_c(cmd_arg_c), .cmd_reg(cmd_reg), .cmd_ready(cmd_ready), .ack(ack), .ack_thread(ack_thread),
    .thread_wait(thread_wait), .pos_err(pos_err), .peak_error(peak_error), .prog_run(prog_run),
    .host_mode(host_mode), .prog_stop(prog_stop), .loop_branch(loop_branch), .loop_done(loop_done),
    .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data), .pb_load_done(pb_load_done),
    .pb_load_end_addr(pb_load_end_addr), .pb_wr_en(pb_wr_en), .pb_wr_addr(pb_wr_addr), .pb_wr_data(pb_wr_data));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // a result with no note left is itself a mismatch
  task automatic pop(ref logic [31:0] q[$], input logic [31:0] got);
    cmp(got, (q.size() != 0) ? q.pop_front() : ~got);
  endtask

  // pulses stand one cycle, so look once per cycle once settled
  always @(posedge clock)
  begin
    #2;
    if (ack === 1'b1) pop(q_ack, {31'h0, ack_thread});
    if (reg_wr_en === 1'b1) pop(q_wr, reg_wr_data);
    if (reg_wr_en === 1'b1) pop(q_wa, {16'h0, reg_wr_addr});
    if ((loop_branch | loop_done) === 1'b1) pop(q_loop, {30'h0, loop_branch, loop_done});
    if (rd_valid === 1'b1) pop(q_rd, rd_data);
    if (pb_wr_en === 1'b1) pop(q_pb, {pb_wr_addr, pb_wr_data});
    if (prog_stop === 1'b1) pop(q_stop, 32'h1);
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic cmd(input logic t, input logic [7:0] c, input logic [31:0] a, b, i, input logic [15:0] r);
    q_ack.push_back({31'h0, t});
    i_host.send(t, c, a, b, i, r);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    q_rd.push_back(x);
    rd_en = 1'b1;
    rd_addr = a;
    cyc(1);
    rd_en = 1'b0;
    rd_addr = ~a;
  endtask

  task automatic nxt(input logic t, input logic [15:0] r, input logic [31:0] v, input logic br);
    q_wr.push_back(v);
    q_wa.push_back({16'h0, r});
    q_loop.push_back({30'h0, br, ~br});
    cmd(t, MPF_CMD_LOOP_NEXT, 32'h0, 32'h0, 32'h0, r);
  endtask

  // length of thread zero's hold, bounded
  task automatic hold_len(input int lo, input int hi);
    n = 0;
    while (thread_wait[0] === 1'b1 && n <= hi)
    begin
      cyc(1);
      n++;
    end
    cmp(32'(n >= lo && n <= hi), 32'h1);
  endtask

  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles expected
  initial
  begin
    #200000;
    failures++;
    end_of_test();
  end

  initial
  begin
    pos_err = 32'h0;
    prog_run = 1'b0;
    rd_en = 1'b0;
    rd_addr = 16'h0;
    pb_load_done = 1'b0;
    pb_load_end_addr = 16'h0;
    void'($urandom(32'h2013));
    cyc(10);
    sys_rst = 1'b0;
    cmp({cmd_ready, host_mode, thread_wait, peak_error}, 20'hc0000);
    // peak tracking, saturation and clear
    e = 32'd300 + ($urandom % 100);
    pos_err = -e;
    cyc(2 * TC);
    rd(MPF_REG_PEAK, e);
    pos_err = 32'd5;
    cyc(2 * TC);
    rd(MPF_REG_PEAK, e);
    pos_err = 32'h0001_0000;
    cyc(2 * TC);
    rd(MPF_REG_PEAK, 32'h7fff);
    cmp(peak_error, 32'h7fff);
    pos_err = 32'h0;
    cmd(1'b1, MPF_CMD_CLEAR_PEAK, 32'h0, 32'h0, 32'h0, 16'h0);
    rd(MPF_REG_PEAK, 32'h0);
    $display("peak test done");
    // positive count holds, shared counter reloaded by the other thread
    e = 32'd2 + ($urandom % 4);
    cmd(1'b0, MPF_CMD_TICK_DELAY, e, 32'h0, 32'h0, 16'h0);
    cmp(thread_wait, 2'b01);
    rd(MPF_REG_DELAY, e);
    hold_len((e - 1) * TC - 2, e * TC + 2);
    cmd(1'b0, MPF_CMD_TICK_DELAY, 32'd3, 32'h0, 32'h0, 16'h0);
    q_ack.push_back(32'h1);
    i_host.send_ms(1'b1, -1);
    cmp(thread_wait, 2'b01);
    rd(MPF_REG_DELAY, 32'd8);
    hold_len(7 * TC - 2, 8 * TC + 2);
    $display("delay test done");
    // end in host mode, then from a running program
    cmd(1'b0, MPF_CMD_END, 32'h0, 32'h0, 32'h0, 16'h0);
    cmp(host_mode, 1'b1);
    prog_run = 1'b1;
    cyc(1);
    prog_run = 1'b0;
    cmp(host_mode, 1'b0);
    q_stop.push_back(32'h1);
    cmd(1'b1, MPF_CMD_END, 32'h0, 32'h0, 32'h0, 16'h0);
    cmp(host_mode, 1'b1);
    i_host.send(1'b0, 8'h55, 32'h0, 32'h0, 32'h0, 16'h0);
    pb_load_end_addr = 16'($urandom);
    q_pb.push_back({pb_load_end_addr + 16'h1, 16'h0080});
    pb_load_done = 1'b1;
    cyc(1);
    pb_load_done = 1'b0;
    pb_load_end_addr = ~pb_load_end_addr;
    $display("end test done");
    // nested loops: outer counts up, inner counts down
    q_wr.push_back(32'd0);
    q_wa.push_back(32'd29);
    cmd(1'b0, MPF_CMD_LOOP_START, 32'd0, 32'd1, 32'd1, 16'd29);
    q_wr.push_back(32'd1);
    q_wa.push_back(32'd30);
    cmd(1'b1, MPF_CMD_LOOP_START, 32'd1, 32'd0, 32'hffff_ffff, 16'd30);
    nxt(1'b1, 16'd30, 32'd0, 1'b1);
    nxt(1'b1, 16'd30, 32'hffff_ffff, 1'b0);
    nxt(1'b0, 16'd29, 32'd1, 1'b1);
    nxt(1'b0, 16'd29, 32'd2, 1'b0);
    cyc(4);
    cmp(q_ack.size() + q_wr.size() + q_wa.size() + q_loop.size() + q_rd.size() + q_pb.size() + q_stop.size(), 0);
    $display("loop test done");
    end_of_test();
  end
endmodule
